// ### hw/ddrci_buf.sv
// Two-entry buffer for captured write beats, valid and ready on both sides.
// Assumes the filler honours o_ready and the drain may stall at will.
`timescale 1ns/1ps
module ddrci_buf #(
    parameter int W = 36
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_valid,
    input wire logic [W-1:0] i_data,
    output logic o_ready,
    output logic o_valid,
    output logic [W-1:0] o_data,
    input wire logic i_ready
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0] vld;
        logic [1:0][W-1:0] ent;
        logic room;
    } ddrci_buf_type;

    ddrci_buf_type st_q;
    ddrci_buf_type st_d;

    always_comb begin
        logic pop;
        logic push;
        pop = 1'b0;
        push = 1'b0;
        st_d = st_q;
        pop = st_q.vld[0] & i_ready;
        push = i_valid & st_q.room;
        if (pop) begin
            st_d.ent[0] = st_q.ent[1];
            st_d.vld = {1'b0, st_q.vld[1]};
        end
        if (push) begin
            st_d.ent[st_d.vld[0]] = i_data;
            st_d.vld[st_d.vld[0]] = 1'b1;
        end
        st_d.room = ~st_d.vld[1];
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_q <= '{vld: 2'h0, ent: '0, room: 1'b1};
        end else begin
            st_q <= st_d;
        end
    end

    assign o_ready = st_q.room;
    assign o_valid = st_q.vld[0];
    assign o_data = st_q.ent[0];

endmodule : ddrci_buf

// ### hw/ddrci_pkg.sv
// Package of the DDR command and write-mask input interface.
// Assumes one system clock standing for the rising CK crossing.
package ddrci_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int ADDR_W = 13;
    localparam int BANK_W = 2;
    localparam int NUM_BANKS = 4;
    localparam int DQ_W = 32;
    localparam int LANES = 4;
    localparam int LANE_W = 8;
    localparam int X16_LANES = 2;

    // ----------------------------------------------------------------
    // Address field positions
    // ----------------------------------------------------------------
    localparam int TOP_ADDR_BIT = 12;
    localparam int AP_BIT_X32 = 8;
    localparam int AP_BIT_X16 = 10;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_RST = 13'h0000;
    localparam logic [BANK_W-1:0] BANK_RST = 2'h0;
    localparam logic [NUM_BANKS-1:0] OPEN_RST = 4'h0;
    localparam logic [DQ_W-1:0] DQ_RST = 32'h00000000;
    localparam logic [LANES-1:0] BE_RST = 4'h0;

    // ----------------------------------------------------------------
    // Commands and power states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        CMD_NOP,
        CMD_ACTIVE,
        CMD_READ,
        CMD_WRITE,
        CMD_BURST_STOP,
        CMD_PRECHARGE,
        CMD_REFRESH,
        CMD_MODE_SET
    } ddrci_cmd_type;

    typedef enum logic [1:0] {
        PWR_NORMAL,
        PWR_PRE_PD,
        PWR_ACT_PD,
        PWR_SELF_REF
    } ddrci_pwr_type;

endpackage : ddrci_pkg

// ### hw/ddrci_top.sv
// DDR command, clock-enable and write-mask input interface of the memory.
// Assumes I_SYS_CLK is the rising CK crossing and all inputs but the asynchronous reset I_RST_B are synchronous.
`timescale 1ns/1ps
module ddrci_top (
    input wire logic I_SYS_CLK,
    input wire logic I_RST_B,
    input wire logic I_CFG_X32,
    input wire logic I_CKE,
    input wire logic I_CS_B,
    input wire logic I_RAS_B,
    input wire logic I_CAS_B,
    input wire logic I_WE_B,
    input wire logic [ddrci_pkg::BANK_W-1:0] I_BA,
    input wire logic [ddrci_pkg::ADDR_W-1:0] I_ADDR,
    input wire logic I_DQS,
    input wire logic [ddrci_pkg::DQ_W-1:0] I_DQ,
    input wire logic [ddrci_pkg::LANES-1:0] I_DM,
    input wire logic I_WR_READY,
    output logic O_CMD_VALID,
    output logic [2:0] O_CMD,
    output logic [ddrci_pkg::BANK_W-1:0] O_BANK,
    output logic [ddrci_pkg::ADDR_W-1:0] O_ADDR,
    output logic O_AP,
    output logic [ddrci_pkg::NUM_BANKS-1:0] O_BANK_OPEN,
    output logic [1:0] O_PWR_STATE,
    output logic O_INT_CLK_EN,
    output logic O_IN_BUF_EN,
    output logic O_OUT_DRV_EN,
    output logic O_BEAT_READY,
    output logic O_OVERRUN,
    output logic O_WR_VALID,
    output logic [ddrci_pkg::DQ_W-1:0] O_WR_DATA,
    output logic [ddrci_pkg::LANES-1:0] O_WR_BE
);

    // ----------------------------------------------------------------
    // Decoding helpers
    // ----------------------------------------------------------------
    function automatic ddrci_pkg::ddrci_cmd_type cmd_decode(
        input logic ras_b,
        input logic cas_b,
        input logic we_b
    );
        case ({ras_b, cas_b, we_b})
            3'h3: cmd_decode = ddrci_pkg::CMD_ACTIVE;
            3'h5: cmd_decode = ddrci_pkg::CMD_READ;
            3'h4: cmd_decode = ddrci_pkg::CMD_WRITE;
            3'h6: cmd_decode = ddrci_pkg::CMD_BURST_STOP;
            3'h2: cmd_decode = ddrci_pkg::CMD_PRECHARGE;
            3'h1: cmd_decode = ddrci_pkg::CMD_REFRESH;
            3'h0: cmd_decode = ddrci_pkg::CMD_MODE_SET;
            default: cmd_decode = ddrci_pkg::CMD_NOP;
        endcase
    endfunction : cmd_decode

    function automatic logic ap_of(
        input logic [ddrci_pkg::ADDR_W-1:0] addr,
        input logic x32
    );
        ap_of = x32 ? addr[ddrci_pkg::AP_BIT_X32] : addr[ddrci_pkg::AP_BIT_X16];
    endfunction : ap_of

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        ddrci_pkg::ddrci_pwr_type pwr;
        logic [ddrci_pkg::NUM_BANKS-1:0] open;
        logic wr_act;
        logic dqs;
        logic cmd_vld;
        ddrci_pkg::ddrci_cmd_type cmd;
        logic [ddrci_pkg::BANK_W-1:0] bank;
        logic [ddrci_pkg::ADDR_W-1:0] addr;
        logic ap;
        logic ovr;
        logic int_clk;
        logic ibuf;
        logic obuf;
    } ddrci_state_type;

    ddrci_state_type st_q;
    ddrci_state_type st_d;

    ddrci_pkg::ddrci_cmd_type cmd_in;
    logic [ddrci_pkg::ADDR_W-1:0] addr_in;
    logic ap_in;
    logic cmd_live;
    logic beat_edge;
    logic beat_push;
    logic buf_ready;
    logic [ddrci_pkg::LANES-1:0] beat_be;
    logic [ddrci_pkg::LANES-1:0] lane_used;

    // ----------------------------------------------------------------
    // Command decode and byte lanes
    // ----------------------------------------------------------------
    assign cmd_live = (st_q.pwr == ddrci_pkg::PWR_NORMAL) & ~I_CS_B;
    assign cmd_in = cmd_live ? cmd_decode(I_RAS_B, I_CAS_B, I_WE_B)
                             : ddrci_pkg::CMD_NOP;
    assign addr_in = I_CFG_X32 ? {1'b0, I_ADDR[ddrci_pkg::TOP_ADDR_BIT-1:0]}
                               : I_ADDR;
    assign ap_in = ap_of(I_ADDR, I_CFG_X32);

    generate
        for (genvar g = 0; g < ddrci_pkg::LANES; g++) begin : g_lane
            assign lane_used[g] = I_CFG_X32 | (g < ddrci_pkg::X16_LANES);
            assign beat_be[g] = lane_used[g] & ~I_DM[g];
        end
    endgenerate

    // Either strobe direction marks one beat with its own mask value
    assign beat_edge = I_DQS ^ st_q.dqs;
    assign beat_push = beat_edge & st_q.wr_act & st_q.ibuf;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.dqs = I_DQS;
        st_d.cmd_vld = 1'b0;
        if (beat_push && !buf_ready) begin
            st_d.ovr = 1'b1;
        end
        case (st_q.pwr)
            ddrci_pkg::PWR_NORMAL: begin
                if (!I_CKE) begin
                    st_d.wr_act = 1'b0;
                    if (st_q.open != ddrci_pkg::OPEN_RST) begin
                        st_d.pwr = ddrci_pkg::PWR_ACT_PD;
                    end else if (cmd_in == ddrci_pkg::CMD_REFRESH) begin
                        st_d.pwr = ddrci_pkg::PWR_SELF_REF;
                    end else begin
                        st_d.pwr = ddrci_pkg::PWR_PRE_PD;
                    end
                end else if (cmd_in != ddrci_pkg::CMD_NOP) begin
                    st_d.cmd_vld = 1'b1;
                    st_d.cmd = cmd_in;
                    st_d.bank = I_BA;
                    st_d.addr = addr_in;
                    st_d.ap = 1'b0;
                    st_d.wr_act = 1'b0;
                    case (cmd_in)
                        ddrci_pkg::CMD_ACTIVE: begin
                            st_d.open[I_BA] = 1'b1;
                        end
                        ddrci_pkg::CMD_READ: begin
                            st_d.ap = ap_in;
                            if (ap_in) begin
                                st_d.open[I_BA] = 1'b0;
                            end
                        end
                        ddrci_pkg::CMD_WRITE: begin
                            st_d.ap = ap_in;
                            st_d.wr_act = 1'b1;
                            st_d.ovr = beat_push & ~buf_ready;
                            if (ap_in) begin
                                st_d.open[I_BA] = 1'b0;
                            end
                        end
                        ddrci_pkg::CMD_PRECHARGE: begin
                            st_d.ap = ap_in;
                            if (ap_in) begin
                                st_d.open = ddrci_pkg::OPEN_RST;
                            end else begin
                                st_d.open[I_BA] = 1'b0;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
            ddrci_pkg::PWR_SELF_REF: begin
                // Exit needs no command decode, only I_CKE high at a rising edge
                if (I_CKE) begin
                    st_d.pwr = ddrci_pkg::PWR_NORMAL;
                end
            end
            default: begin
                if (I_CKE) begin
                    st_d.pwr = ddrci_pkg::PWR_NORMAL;
                end
            end
        endcase
        st_d.int_clk = (st_d.pwr == ddrci_pkg::PWR_NORMAL);
        st_d.ibuf = (st_d.pwr == ddrci_pkg::PWR_NORMAL);
        st_d.obuf = (st_d.pwr == ddrci_pkg::PWR_NORMAL);
    end

    // ----------------------------------------------------------------
    // Registers, sampled on the rising crossing only
    // ----------------------------------------------------------------
    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            st_q <= '{pwr: ddrci_pkg::PWR_NORMAL, open: ddrci_pkg::OPEN_RST,
                      wr_act: 1'b0, dqs: 1'b0, cmd_vld: 1'b0,
                      cmd: ddrci_pkg::CMD_NOP, bank: ddrci_pkg::BANK_RST,
                      addr: ddrci_pkg::ADDR_RST, ap: 1'b0, ovr: 1'b0,
                      int_clk: 1'b1, ibuf: 1'b1, obuf: 1'b1};
        end else begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------------------------------
    // Write beat buffer
    // ----------------------------------------------------------------
    ddrci_buf #(
        .W(ddrci_pkg::DQ_W + ddrci_pkg::LANES)
    ) u_buf (
        .i_clk(I_SYS_CLK),
        .i_rst_b(I_RST_B),
        .i_valid(beat_push),
        .i_data({beat_be, I_DQ}),
        .o_ready(buf_ready),
        .o_valid(O_WR_VALID),
        .o_data({O_WR_BE, O_WR_DATA}),
        .i_ready(I_WR_READY)
    );

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign O_CMD_VALID = st_q.cmd_vld;
    assign O_CMD = st_q.cmd;
    assign O_BANK = st_q.bank;
    assign O_ADDR = st_q.addr;
    assign O_AP = st_q.ap;
    assign O_BANK_OPEN = st_q.open;
    assign O_PWR_STATE = st_q.pwr;
    assign O_INT_CLK_EN = st_q.int_clk;
    assign O_IN_BUF_EN = st_q.ibuf;
    assign O_OUT_DRV_EN = st_q.obuf;
    assign O_BEAT_READY = buf_ready;
    assign O_OVERRUN = st_q.ovr;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (!I_RST_B);

    a_cs_masks_cmd: assert property (
        I_CS_B |=> !O_CMD_VALID)
        else $error("command issued while chip select high");

    a_cmd_active_code: assert property (
        st_q.pwr == ddrci_pkg::PWR_NORMAL && I_CKE && !I_CS_B
        && !I_RAS_B && I_CAS_B && I_WE_B
        |=> O_CMD_VALID && O_CMD == ddrci_pkg::CMD_ACTIVE
            && O_BANK_OPEN[O_BANK])
        else $error("active command not decoded");

    a_bank_routed: assert property (
        st_q.pwr == ddrci_pkg::PWR_NORMAL && I_CKE && !I_CS_B
        && !(I_RAS_B && I_CAS_B && I_WE_B)
        |=> O_CMD_VALID && O_BANK == $past(I_BA))
        else $error("bank address not carried with command");

    a_top_addr_gone: assert property (
        O_CMD_VALID && $past(I_CFG_X32) |-> !O_ADDR[ddrci_pkg::TOP_ADDR_BIT])
        else $error("top address line used in thirty-two-bit mode");

    a_nop_quiet: assert property (
        !I_CS_B && I_RAS_B && I_CAS_B && I_WE_B |=> !O_CMD_VALID)
        else $error("no-operation produced a command");

    a_act_pd_entry: assert property (
        st_q.pwr == ddrci_pkg::PWR_NORMAL && !I_CKE && st_q.open != 4'h0
        |=> O_PWR_STATE == ddrci_pkg::PWR_ACT_PD)
        else $error("open row did not enter active power-down");

    a_pd_bufs_off: assert property (
        O_PWR_STATE != ddrci_pkg::PWR_NORMAL
        |-> !O_INT_CLK_EN && !O_IN_BUF_EN && !O_OUT_DRV_EN)
        else $error("enables left on in power-down");

    a_pd_no_beats: assert property (
        O_PWR_STATE != ddrci_pkg::PWR_NORMAL |-> !beat_push ##1 !O_CMD_VALID)
        else $error("input taken during power-down");

    a_sr_exit: assert property (
        st_q.pwr == ddrci_pkg::PWR_SELF_REF && I_CKE
        |=> O_PWR_STATE == ddrci_pkg::PWR_NORMAL && O_IN_BUF_EN)
        else $error("self-refresh exit missed");

    a_mask_lane: assert property (
        beat_push && I_DM[0] |-> !beat_be[0])
        else $error("masked byte enabled");

    a_x16_lanes: assert property (
        beat_push && !I_CFG_X32 |-> beat_be[3:2] == 2'h0)
        else $error("upper lanes enabled in sixteen-bit mode");

    a_beat_on_edge: assert property (
        beat_push |-> I_DQS != $past(I_DQS))
        else $error("beat taken without strobe edge");

    a_ap_per_cmd: assert property (
        O_CMD_VALID && O_CMD == ddrci_pkg::CMD_READ
        |-> O_AP == $past(ap_of(I_ADDR, I_CFG_X32)))
        else $error("auto-precharge bit not passed");

    a_x32_lanes: assert property (
        beat_push && I_CFG_X32 |-> beat_be == ~I_DM)
        else $error("lane enables not in mask order");

    a_addr_carried: assert property (
        O_CMD_VALID && !$past(I_CFG_X32) |-> O_ADDR == $past(I_ADDR))
        else $error("address not carried with command");

    a_ap_closes_bank: assert property (
        st_q.pwr == ddrci_pkg::PWR_NORMAL && I_CKE && !I_CS_B
        && I_RAS_B && !I_CAS_B && ap_in
        |=> !O_BANK_OPEN[$past(I_BA)])
        else $error("auto-precharge left bank open");

    c_write_burst: cover property (
        O_CMD_VALID && O_CMD == ddrci_pkg::CMD_WRITE ##[1:8] O_WR_VALID);
    c_self_ref: cover property (
        O_PWR_STATE == ddrci_pkg::PWR_SELF_REF ##[1:20] O_IN_BUF_EN);
    c_buf_full: cover property (!O_BEAT_READY);
    c_act_pd: cover property (O_PWR_STATE == ddrci_pkg::PWR_ACT_PD);

endmodule : ddrci_top

// ### verif/ddrci_ctrl_model.sv
// Far-side memory controller model: drives command, address, strobe, data and mask pins.
// Assumes tasks are called from one bench process, just after a rising edge of i_clk.
`timescale 1ns/1ps
module ddrci_ctrl_model (
    input wire logic i_clk,
    output logic o_cke,
    output logic o_cs_b,
    output logic o_ras_b,
    output logic o_cas_b,
    output logic o_we_b,
    output logic [ddrci_pkg::BANK_W-1:0] o_ba,
    output logic [ddrci_pkg::ADDR_W-1:0] o_addr,
    output logic o_dqs,
    output logic [ddrci_pkg::DQ_W-1:0] o_dq,
    output logic [ddrci_pkg::LANES-1:0] o_dm
);
    // ------------------------------------------------------------
    // Pin levels RAS CAS WE for each command code
    // ------------------------------------------------------------
    logic [2:0] enc_tab [8];

    initial begin
        enc_tab = '{3'h7, 3'h3, 3'h5, 3'h4, 3'h6, 3'h2, 3'h1, 3'h0};
        o_cke = 1'b1;
        o_cs_b = 1'b1;
        {o_ras_b, o_cas_b, o_we_b} = 3'h7;
        o_ba = 2'h0;
        o_addr = 13'h0000;
        o_dqs = 1'b0;
        o_dq = 32'h00000000;
        o_dm = 4'h0;
    end

    // ------------------------------------------------------------
    // One command for one cycle, then deselect
    // ------------------------------------------------------------
    task issue(input logic [2:0] cmd, input logic [1:0] ba, input logic [12:0] addr,
               input logic cke, input logic cs_b);
        @(posedge i_clk);
        #1;
        o_cke = cke;
        o_cs_b = cs_b;
        {o_ras_b, o_cas_b, o_we_b} = enc_tab[cmd];
        o_ba = ba;
        o_addr = addr;
        @(posedge i_clk);
        #1;
        o_cs_b = 1'b1;
        {o_ras_b, o_cas_b, o_we_b} = 3'h7;
        o_ba = ~o_ba;
        o_addr = ~o_addr;
    endtask : issue

    // ------------------------------------------------------------
    // One write beat: strobe toggles with data and mask
    // ------------------------------------------------------------
    task beat(input logic [31:0] dq, input logic [3:0] dm);
        @(posedge i_clk);
        #1;
        o_dq = dq;
        o_dm = dm;
        o_dqs = ~o_dqs;
        @(posedge i_clk);
        #1;
        o_dq = ~o_dq;
        o_dm = ~o_dm;
    endtask : beat

    task set_cke(input logic v);
        @(posedge i_clk);
        #1;
        o_cke = v;
        @(posedge i_clk);
        #1;
    endtask : set_cke
endmodule : ddrci_ctrl_model

// ### verif/test_ddrci_top.sv
// Self-checking bench for the command and write-mask input interface.
// Assumes the controller model drives all command and data pins.
`timescale 1ns/1ps
module test_ddrci_top;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic cfg_x32 = 1'b1;
    logic wr_ready = 1'b1;
    logic cke, cs_b, ras_b, cas_b, we_b, dqs;
    logic [1:0] ba;
    logic [12:0] addr;
    logic [31:0] dq;
    logic [3:0] dm;
    logic cmd_valid, ap, clk_en, buf_en, drv_en, beat_ready, overrun, wr_valid;
    logic [2:0] cmd;
    logic [1:0] bank, pwr;
    logic [12:0] o_addr;
    logic [3:0] bank_open, wr_be;
    logic [31:0] wr_data;
    int err_total = 0;
    int checks_done = 0;

    always #50 clk = ~clk;

    ddrci_ctrl_model ctrl (.i_clk(clk), .o_cke(cke), .o_cs_b(cs_b), .o_ras_b(ras_b),
        .o_cas_b(cas_b), .o_we_b(we_b), .o_ba(ba), .o_addr(addr), .o_dqs(dqs), .o_dq(dq),
        .o_dm(dm));

    ddrci_top dut (.I_SYS_CLK(clk), .I_RST_B(rst_b), .I_CFG_X32(cfg_x32), .I_CKE(cke),
        .I_CS_B(cs_b), .I_RAS_B(ras_b), .I_CAS_B(cas_b), .I_WE_B(we_b), .I_BA(ba),
        .I_ADDR(addr), .I_DQS(dqs), .I_DQ(dq), .I_DM(dm), .I_WR_READY(wr_ready),
        .O_CMD_VALID(cmd_valid), .O_CMD(cmd), .O_BANK(bank), .O_ADDR(o_addr), .O_AP(ap),
        .O_BANK_OPEN(bank_open), .O_PWR_STATE(pwr), .O_INT_CLK_EN(clk_en),
        .O_IN_BUF_EN(buf_en), .O_OUT_DRV_EN(drv_en), .O_BEAT_READY(beat_ready),
        .O_OVERRUN(overrun), .O_WR_VALID(wr_valid), .O_WR_DATA(wr_data), .O_WR_BE(wr_be));

    // ------------------------------------------------------------
    // Compare and report
    // ------------------------------------------------------------
    task chk_bit(input string name, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %b seen %b", name, exp, got);
        end
    endtask : chk_bit

    task chk_val(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_val

    task chk_pwr(input logic [1:0] st, input logic en);
        chk_val("pwr", 32'(st), 32'(pwr));
        chk_bit("clk_en", en, clk_en);
        chk_bit("buf_en", en, buf_en);
        chk_bit("drv_en", en, drv_en);
    endtask : chk_pwr

    task summarize;
        $display("Checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_reset;
        chk_pwr(2'h0, 1'b1);
        chk_bit("cmd_valid", 1'b0, cmd_valid);
        chk_bit("beat_ready", 1'b1, beat_ready);
        chk_bit("wr_valid", 1'b0, wr_valid);
        chk_val("bank_open", 32'h0, 32'(bank_open));
        $display("test reset done");
    endtask : t_reset

    task t_decode;
        ctrl.issue(3'h0, 2'h1, 13'h0001, 1'b1, 1'b0);
        chk_bit("cmd_valid", 1'b0, cmd_valid);
        ctrl.issue(3'h1, 2'h1, 13'h0001, 1'b1, 1'b1);
        chk_bit("cmd_valid", 1'b0, cmd_valid);
        ctrl.issue(3'h1, 2'h2, 13'h1ABC, 1'b1, 1'b0);
        chk_bit("cmd_valid", 1'b1, cmd_valid);
        chk_val("cmd", 32'h1, 32'(cmd));
        chk_val("bank", 32'h2, 32'(bank));
        chk_val("addr", 32'h0ABC, 32'(o_addr));
        chk_val("bank_open", 32'h4, 32'(bank_open));
        @(posedge clk);
        #1;
        chk_bit("cmd_valid", 1'b0, cmd_valid);
        ctrl.issue(3'h7, 2'h0, 13'h0123, 1'b1, 1'b0);
        chk_val("cmd", 32'h7, 32'(cmd));
        chk_val("addr", 32'h0123, 32'(o_addr));
        ctrl.issue(3'h6, 2'h0, 13'h0000, 1'b1, 1'b0);
        chk_val("cmd", 32'h6, 32'(cmd));
        chk_pwr(2'h0, 1'b1);
        ctrl.issue(3'h4, 2'h3, 13'h0000, 1'b1, 1'b0);
        chk_val("cmd", 32'h4, 32'(cmd));
        chk_val("bank_open", 32'h4, 32'(bank_open));
        $display("test decode done");
    endtask : t_decode

    task t_power;
        ctrl.set_cke(1'b0);
        chk_pwr(2'h2, 1'b0);
        ctrl.issue(3'h1, 2'h1, 13'h0002, 1'b0, 1'b0);
        chk_bit("cmd_valid", 1'b0, cmd_valid);
        ctrl.set_cke(1'b1);
        chk_pwr(2'h0, 1'b1);
        $display("test power done");
    endtask : t_power

    task t_write;
        ctrl.issue(3'h3, 2'h2, 13'h1100, 1'b1, 1'b0);
        chk_val("cmd", 32'h3, 32'(cmd));
        chk_val("addr", 32'h0100, 32'(o_addr));
        chk_bit("ap", 1'b1, ap);
        chk_val("bank_open", 32'h0, 32'(bank_open));
        wr_ready = 1'b0;
        ctrl.beat(32'h11223344, 4'h5);
        chk_bit("wr_valid", 1'b1, wr_valid);
        chk_val("wr_data", 32'h11223344, wr_data);
        chk_val("wr_be", 32'hA, 32'(wr_be));
        ctrl.beat(32'h55667788, 4'h0);
        chk_bit("beat_ready", 1'b0, beat_ready);
        ctrl.beat(32'h99AABBCC, 4'hF);
        chk_bit("overrun", 1'b1, overrun);
        chk_val("wr_data", 32'h11223344, wr_data);
        wr_ready = 1'b1;
        @(posedge clk);
        #1;
        chk_val("wr_data", 32'h55667788, wr_data);
        chk_val("wr_be", 32'hF, 32'(wr_be));
        @(posedge clk);
        #1;
        chk_bit("wr_valid", 1'b0, wr_valid);
        $display("test write done");
    endtask : t_write

    task t_x16;
        cfg_x32 = 1'b0;
        ctrl.issue(3'h2, 2'h1, 13'h1400, 1'b1, 1'b0);
        chk_val("cmd", 32'h2, 32'(cmd));
        chk_val("addr", 32'h1400, 32'(o_addr));
        chk_bit("ap", 1'b1, ap);
        ctrl.issue(3'h3, 2'h0, 13'h0000, 1'b1, 1'b0);
        chk_bit("ap", 1'b0, ap);
        chk_bit("overrun", 1'b0, overrun);
        ctrl.beat(32'hCAFE1234, 4'h2);
        chk_val("wr_be", 32'h1, 32'(wr_be));
        ctrl.issue(3'h1, 2'h3, 13'h0000, 1'b1, 1'b0);
        ctrl.issue(3'h1, 2'h1, 13'h0000, 1'b1, 1'b0);
        chk_val("bank_open", 32'hA, 32'(bank_open));
        ctrl.issue(3'h5, 2'h3, 13'h0000, 1'b1, 1'b0);
        chk_val("bank_open", 32'h2, 32'(bank_open));
        ctrl.issue(3'h5, 2'h0, 13'h0400, 1'b1, 1'b0);
        chk_val("bank_open", 32'h0, 32'(bank_open));
        chk_bit("ap", 1'b1, ap);
        $display("test x16 done");
    endtask : t_x16

    task t_self_ref;
        ctrl.issue(3'h6, 2'h0, 13'h0000, 1'b0, 1'b0);
        chk_pwr(2'h3, 1'b0);
        ctrl.set_cke(1'b1);
        chk_pwr(2'h0, 1'b1);
        ctrl.set_cke(1'b0);
        chk_pwr(2'h1, 1'b0);
        ctrl.set_cke(1'b1);
        $display("test self refresh done");
    endtask : t_self_ref

    initial begin
        repeat (3000) @(posedge clk);
        err_total++;
        $display("[ERR] watchdog expected end seen timeout");
        summarize();
    end

    initial begin
        repeat (16) @(posedge clk);
        #1;
        rst_b = 1'b1;
        t_reset();
        t_decode();
        t_power();
        t_write();
        t_x16();
        t_self_ref();
        summarize();
    end
endmodule : test_ddrci_top
